//--- hw/arec_pkg.sv
// Package for the converter result and debug-suspend control block.
// Assumes a single 50 MHz clock domain and a plain strobe register port.
package arec_pkg;

    // Register port widths
    localparam int AREC_AW = 8;  // Byte address width
    localparam int AREC_DW = 32; // Register data width
    localparam int AREC_RW = 10; // Conversion result width

    // Register byte offsets, one aligned word each
    localparam logic [AREC_AW-1:0] AREC_OFF_CH3 = 8'h00;  // channel3_result
    localparam logic [AREC_AW-1:0] AREC_OFF_CH4 = 8'h04;  // channel4_result
    localparam logic [AREC_AW-1:0] AREC_OFF_CH5 = 8'h08;  // channel5_result
    localparam logic [AREC_AW-1:0] AREC_OFF_EMU = 8'h0C;  // debug_suspend_control
    localparam logic [AREC_AW-1:0] AREC_OFF_STAT = 8'h10; // suspend_status

    // Channel numbers carried by the core's result strobe
    localparam logic [2:0] AREC_CH3 = 3'h3;
    localparam logic [2:0] AREC_CH4 = 3'h4;
    localparam logic [2:0] AREC_CH5 = 3'h5;

    // Field positions in debug_suspend_control
    localparam int AREC_FREE_POS = 0;  // Free-run, writable
    localparam int AREC_SOFT_POS = 1;  // Soft stop, read-only
    localparam int AREC_RTSEL_POS = 2; // realtime_select, read-only

    // Field positions in suspend_status
    localparam int AREC_ST_HALT_POS = 0;  // Halted
    localparam int AREC_ST_DRAIN_POS = 1; // Waiting for task end
    localparam int AREC_ST_SUSP_POS = 2;  // Synchronised suspend level

    // Reset and fixed values
    localparam logic AREC_FREE_RST = 1'h1;      // Free-run after reset
    localparam logic AREC_SOFT_VAL = 1'h1;      // Soft stop only
    localparam logic AREC_RTSEL_VAL = 1'h0;     // Emulation suspend only
    localparam logic [AREC_RW-1:0] AREC_RES_RST = 10'h000;

    // Suspend controller states, one-hot
    typedef enum logic [2:0] {
        AREC_ST_RUN = 3'h1,   // Normal operation
        AREC_ST_DRAIN = 3'h2, // Finishing the task in progress
        AREC_ST_HALT = 3'h4   // Activity stopped
    } arec_state_t;

    // All state of the block
    typedef struct packed {
        arec_state_t state;       // Suspend controller
        logic [AREC_RW-1:0] res3; // Channel 3 result
        logic [AREC_RW-1:0] res4; // Channel 4 result
        logic [AREC_RW-1:0] res5; // Channel 5 result
        logic free;               // Free-run control
        logic susp_m;             // Suspend synchroniser, first stage
        logic susp_s;             // Suspend synchroniser, second stage
        logic halt;               // Halt request to the core
        logic [AREC_DW-1:0] rdata; // Read data register
    } arec_regs_t;

    localparam arec_regs_t AREC_REGS_RST = '{
        state: AREC_ST_RUN,
        res3: AREC_RES_RST,
        res4: AREC_RES_RST,
        res5: AREC_RES_RST,
        free: AREC_FREE_RST,
        susp_m: 1'h0,
        susp_s: 1'h0,
        halt: 1'h0,
        rdata: 32'h0000_0000
    };

endpackage

//--- hw/arec_ctrl.sv
// Result registers for channels 3 to 5 and the debug-suspend controller.
// Assumes the converter core shares mclk and signals finished results with
// a one-cycle strobe; the suspend level comes from another domain.
module arec_ctrl
    import arec_pkg::*;
(
    input wire logic mclk,                    // 50 MHz peripheral clock
    input wire logic rstn,                    // Asynchronous reset, active low
    input wire logic [AREC_AW-1:0] reg_addr,  // Register byte address
    input wire logic [AREC_DW-1:0] reg_wdata, // Write data
    input wire logic reg_wr,                  // Write strobe
    input wire logic reg_rd,                  // Read strobe
    output logic [AREC_DW-1:0] reg_rdata,     // Read data, cycle after strobe
    input wire logic res_valid,               // Core result strobe
    input wire logic [2:0] res_chan,          // Channel of the result
    input wire logic [AREC_RW-1:0] res_data,  // Result value
    input wire logic conv_busy,               // Core task in progress
    input wire logic emu_suspend,             // Debug suspend, asynchronous
    output logic periph_halt                  // Core must not start new work
);

    // Widen a result to a bus word with zero upper bits
    function automatic logic [AREC_DW-1:0] zext_res(input logic [AREC_RW-1:0] v);
        zext_res = {{(AREC_DW - AREC_RW){1'b0}}, v};
    endfunction

    arec_regs_t q; // Registered state
    arec_regs_t d; // Next state
    logic stop_req; // Suspend in force
    logic accept;   // Result strobe taken

    // Next-state logic for the whole block
    always_comb begin
        d = q;
        // Two flops before the suspend level is used
        d.susp_m = emu_suspend;
        d.susp_s = q.susp_m;
        // Free-run masks the suspend completely
        stop_req = !q.free && q.susp_s;
        // Results land in running and draining states; a halted core
        // delivers none, and a stray strobe must not disturb held values
        accept = res_valid && (q.state != AREC_ST_HALT);
        if (accept) begin
            unique case (res_chan)
                AREC_CH3: begin
                    d.res3 = res_data;
                end
                AREC_CH4: begin
                    d.res4 = res_data;
                end
                AREC_CH5: begin
                    d.res5 = res_data;
                end
                default: begin
                    // Other channels belong to other banks
                end
            endcase
        end
        // Only the free-run bit takes a write; reserved bits are dropped
        if (reg_wr && (reg_addr == AREC_OFF_EMU)) begin
            d.free = reg_wdata[AREC_FREE_POS];
        end
        // Suspend controller; soft stop is the only mode
        unique case (q.state)
            AREC_ST_RUN: begin
                if (stop_req) begin
                    d.state = AREC_ST_DRAIN;
                end
            end
            AREC_ST_DRAIN: begin
                // Release or free-run cancels the stop before it lands
                if (!stop_req) begin
                    d.state = AREC_ST_RUN;
                end else if (!conv_busy) begin
                    d.state = AREC_ST_HALT;
                end
            end
            AREC_ST_HALT: begin
                if (!stop_req) begin
                    d.state = AREC_ST_RUN;
                end
            end
            default: begin
                // Recover from an illegal code
                d.state = AREC_ST_RUN;
            end
        endcase
        // Halt is asserted from draining too, so no new task starts
        d.halt = (d.state != AREC_ST_RUN);
        // Read data stands only in the cycle after the strobe
        d.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                AREC_OFF_CH3: begin
                    d.rdata = zext_res(q.res3);
                end
                AREC_OFF_CH4: begin
                    d.rdata = zext_res(q.res4);
                end
                AREC_OFF_CH5: begin
                    d.rdata = zext_res(q.res5);
                end
                AREC_OFF_EMU: begin
                    d.rdata[AREC_FREE_POS] = q.free;
                    d.rdata[AREC_SOFT_POS] = AREC_SOFT_VAL;
                    d.rdata[AREC_RTSEL_POS] = AREC_RTSEL_VAL;
                end
                AREC_OFF_STAT: begin
                    d.rdata[AREC_ST_HALT_POS] = (q.state == AREC_ST_HALT);
                    d.rdata[AREC_ST_DRAIN_POS] = (q.state == AREC_ST_DRAIN);
                    d.rdata[AREC_ST_SUSP_POS] = q.susp_s;
                end
                default: begin
                    // Unmapped addresses read zero
                end
            endcase
        end
    end

    // State register; reset loads constants only
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= AREC_REGS_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from flops
    assign reg_rdata = q.rdata;
    assign periph_halt = q.halt;

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // A taken channel 3 result appears on a read in the following cycle
    ch3_result_a: assert property (
        (accept && res_chan == AREC_CH3) ##1 (reg_rd && reg_addr == AREC_OFF_CH3)
        |=> reg_rdata == zext_res($past(res_data, 2)))
        else $error("channel 3 result not presented");

    ch4_result_a: assert property (
        (res_valid && res_chan == AREC_CH4 && q.state != AREC_ST_HALT)
        |=> q.res4 == $past(res_data))
        else $error("channel 4 result not captured");

    ch5_result_a: assert property (
        (res_valid && res_chan == AREC_CH5 && q.state != AREC_ST_HALT)
        |=> q.res5 == $past(res_data))
        else $error("channel 5 result not captured");

    reserved_zero_a: assert property (
        reg_rd |=> reg_rdata[31:10] == 22'h00_0000)
        else $error("reserved bits read nonzero");

    free_ignores_a: assert property (
        $past(q.free) |-> (q.state == AREC_ST_RUN && !periph_halt))
        else $error("free-run did not ignore suspend");

    suspend_enter_a: assert property (
        (q.state == AREC_ST_RUN && !q.free && q.susp_s)
        |=> q.state == AREC_ST_DRAIN ##0 periph_halt)
        else $error("suspend not entered");

    soft_wait_a: assert property (
        (q.state == AREC_ST_DRAIN && !q.free && q.susp_s)
        |=> (conv_busy[*1] ##0 q.state == AREC_ST_DRAIN)
            or (!$past(conv_busy) ##0 q.state == AREC_ST_HALT)
            or ($past(conv_busy) ##0 q.state == AREC_ST_DRAIN))
        else $error("soft stop did not wait for task");

    emu_read_a: assert property (
        reg_rd && reg_addr == AREC_OFF_EMU
        |=> reg_rdata == {29'h0000_0000, AREC_RTSEL_VAL, AREC_SOFT_VAL, $past(q.free)})
        else $error("suspend control read wrong");

    halt_hold_a: assert property (
        q.state == AREC_ST_HALT
        |=> $stable(q.res3) && $stable(q.res4) && $stable(q.res5))
        else $error("results changed while halted");

    resume_a: assert property (
        (q.state == AREC_ST_HALT && !q.susp_s) |=> q.state == AREC_ST_RUN ##0 !periph_halt)
        else $error("no resume after release");

    drain_to_halt_c: cover property (q.state == AREC_ST_DRAIN ##1 q.state == AREC_ST_HALT);
    halt_resume_c: cover property (q.state == AREC_ST_HALT ##1 q.state == AREC_ST_RUN);
    free_masks_c: cover property (q.free && q.susp_s);
    result_read_c: cover property (accept ##1 reg_rd);

endmodule

//--- sim/arec_core_model.sv
// Behavioural converter core that feeds finished results to the block.
// Assumes the bench pulses start for one cycle; rogue lets it ignore halt.
module arec_core_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic start,
    input wire logic rogue,
    input wire logic [2:0] chan,
    input wire logic [9:0] data,
    input wire logic [3:0] len,
    input wire logic periph_halt,
    output logic res_valid,
    output logic [2:0] res_chan,
    output logic [9:0] res_data,
    output logic conv_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q; // Cycles left in the conversion
    logic [9:0] dat_q; // Value to deliver
    // Data line shows the inverted value outside the strobe
    assign res_data = res_valid ? dat_q : ~dat_q;
    // One conversion at a time; a halt blocks new ones unless rogue
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {cnt_q, dat_q, res_valid, res_chan, conv_busy} <= '0;
        end else begin
            res_valid <= 1'b0;
            if (conv_busy) begin
                cnt_q <= cnt_q - 4'h1;
                conv_busy <= (cnt_q != 4'h0);
                res_valid <= (cnt_q == 4'h0);
            end else if (start && (!periph_halt || rogue)) begin
                {conv_busy, cnt_q, res_chan, dat_q} <= {1'b1, len, chan, data};
            end
        end
    end
endmodule

//--- sim/adc_result_emu_ctrl_test.sv
// Self-checking bench for the result registers and suspend control.
// Assumes the core model beside it and a 50 MHz mclk.
module adc_result_emu_ctrl_test import arec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rstn, reg_wr, reg_rd, start, rogue, emu_suspend;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, rv, seed = 32'h1846;
    logic [2:0] chan;
    logic [9:0] data, expv [8];
    logic [3:0] len;
    wire logic [31:0] reg_rdata;
    // Variables, not nets, so that the bounded wait can watch them by reference
    logic periph_halt, res_valid, conv_busy;
    wire logic [2:0] res_chan;
    wire logic [9:0] res_data;
    int fails = 0, samples_checked = 0;
    always #10 mclk = ~mclk;
    arec_ctrl dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .res_valid(res_valid),
        .res_chan(res_chan), .res_data(res_data), .conv_busy(conv_busy),
        .emu_suspend(emu_suspend), .periph_halt(periph_halt));
    arec_core_model core (.mclk(mclk), .rstn(rstn), .start(start), .rogue(rogue),
        .chan(chan), .data(data), .len(len), .periph_halt(periph_halt),
        .res_valid(res_valid), .res_chan(res_chan), .res_data(res_data),
        .conv_busy(conv_busy));
    // Xorshift source, fixed seed for repeatable runs
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic end_sim();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // One-cycle strobes; read data sampled in the cycle after the strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge mclk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(n, e, reg_rdata);
    endtask
    task automatic launch(input logic [2:0] c, input logic [9:0] d, input logic [3:0] l,
        input logic rg);
        @(posedge mclk);
        {start, chan, data, len, rogue} <= {1'b1, c, d, l, rg};
        @(posedge mclk);
        start <= 1'b0;
    endtask
    // Bounded wait for a signal to reach a level
    task automatic wait_for(input string n, ref logic s, input logic lvl);
        repeat (64) begin
            @(posedge mclk);
            #1;
            if (s === lvl) return;
        end
        chk(n, lvl, s);
        end_sim();
    endtask
    task automatic rd_all();
        for (int c = 3; c < 6; c++) rdchk(8'(4 * (c - 3)), {22'h0, expv[c]}, "result");
    endtask
    initial begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, start, rogue, emu_suspend} = '0;
        {chan, data, len} = '0;
        foreach (expv[i]) expv[i] = 10'h000;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        rd_all();
        rdchk(AREC_OFF_EMU, 32'h0000_0003, "emu_ctrl");
        rdchk(8'h14, 32'h0000_0000, "unmapped");
        $display("test reset done");
        // Random results, some on a channel that is not stored; suspend toggles but
        // free-run must mask it
        repeat (12) begin
            rv = rnd();
            emu_suspend <= rv[31];
            launch(3'h3 + 3'(rv[1:0]), rv[19:10], rv[23:20], 1'b0);
            wait_for("res_valid", res_valid, 1'b1);
            if (rv[1:0] != 2'h3) expv[3'h3 + 3'(rv[1:0])] = rv[19:10];
            chk("periph_halt", 32'h0, {31'h0, periph_halt});
            rd_all();
        end
        emu_suspend <= 1'b0;
        wr(AREC_OFF_CH3, 32'h0);
        rd_all();
        $display("test random results done");
        wr(AREC_OFF_EMU, 32'h0);
        rdchk(AREC_OFF_EMU, 32'h0000_0002, "emu_ctrl");
        // Suspend in mid-conversion: the task finishes and its result lands
        expv[4] = 10'h2A5;
        launch(3'h4, expv[4], 4'hC, 1'b0);
        emu_suspend <= 1'b1;
        wait_for("periph_halt", periph_halt, 1'b1);
        chk("conv_busy", 32'h1, {31'h0, conv_busy});
        wait_for("res_valid", res_valid, 1'b1);
        rdchk(AREC_OFF_STAT, 32'h0000_0005, "status");
        rd_all();
        // Core misbehaves while halted: its result must be dropped
        launch(3'h3, ~expv[3], 4'h2, 1'b1);
        wait_for("res_valid", res_valid, 1'b1);
        rd_all();
        emu_suspend <= 1'b0;
        wait_for("periph_halt", periph_halt, 1'b0);
        expv[5] = 10'h3C3;
        launch(3'h5, expv[5], 4'h3, 1'b0);
        wait_for("res_valid", res_valid, 1'b1);
        rd_all();
        $display("test suspend done");
        wr(AREC_OFF_EMU, 32'h1);
        emu_suspend <= 1'b1;
        repeat (8) @(posedge mclk);
        #1 chk("periph_halt", 32'h0, {31'h0, periph_halt});
        $display("test free run done");
        end_sim();
    end
endmodule
